// File: rtl/cbl_exec.sv
// Execution core for branches, bit ops, shifts, flag ops and indirect loads
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module cbl_exec
  import cbl_pkg::*;
(
  input  logic        core_clk,
  input  logic        rst_n,
  input  logic        instr_valid,
  output logic        instr_ready,
  input  cbl_op_t     instr_op,
  input  logic [4:0]  instr_rd,
  input  logic [4:0]  instr_rr,
  input  logic [2:0]  instr_bit,
  input  logic [5:0]  instr_io,
  input  logic [6:0]  instr_k,
  input  logic [5:0]  instr_q,
  input  logic [1:0]  instr_ptr,
  output logic [5:0]  io_addr,
  output logic        io_rd,
  input  logic [7:0]  io_rdata,
  output logic        io_wr,
  output logic [7:0]  io_wdata,
  output logic [15:0] dm_addr,
  output logic        dm_rd,
  input  logic [7:0]  dm_rdata,
  input  logic [5:0]  reg_addr,
  input  logic [7:0]  reg_wdata,
  input  logic        reg_wr,
  input  logic        reg_rd,
  output logic [7:0]  reg_rdata,
  output logic [15:0] pc_out,
  output logic [7:0]  flags_out
);

  cbl_core_t   s;
  cbl_core_t   n;
  logic        issue;
  logic [7:0]  sh_result;
  logic        sh_c;
  logic        sh_z;
  logic        sh_n;
  logic        sh_v;
  logic        sh_upd;
  logic [4:0]  ptr_lo;
  logic [4:0]  ptr_hi;
  logic [15:0] ptr_val;
  logic [15:0] ptr_dec;
  logic [15:0] ptr_inc;
  logic [15:0] pc_next;
  logic [15:0] pc_branch;
  logic        is_load;
  logic        is_io;
  logic        disp_ok;
  logic [7:0]  bit_mask;
  logic        sw_gpr;
  logic        sw_pc_lo;
  logic        sw_pc_hi;
  logic        sw_flags;
  logic [7:0]  sw_rbyte;

  assign issue       = instr_valid && (s.state == ST_RUN);
  assign instr_ready = (s.state == ST_RUN);

  cbl_shifter u_shifter (
    .op        (instr_op),
    .value     (s.gpr[instr_rd]),
    .carry_in  (s.flags[FLAG_C]),
    .result    (sh_result),
    .carry_out (sh_c),
    .zero_out  (sh_z),
    .neg_out   (sh_n),
    .ovf_out   (sh_v),
    .flags_upd (sh_upd)
  );

  // Pointer pair selection
  always_comb begin
    unique case (instr_ptr)
      PTR_SEL_Y: begin
        ptr_lo = PTR_Y_LO;
        ptr_hi = PTR_Y_HI;
      end
      PTR_SEL_Z: begin
        ptr_lo = PTR_Z_LO;
        ptr_hi = PTR_Z_HI;
      end
      default: begin
        ptr_lo = PTR_X_LO;
        ptr_hi = PTR_X_HI;
      end
    endcase
  end

  assign ptr_val   = {s.gpr[ptr_hi], s.gpr[ptr_lo]};
  assign ptr_dec   = ptr_val - 16'h0001;
  assign ptr_inc   = ptr_val + 16'h0001;
  assign pc_next   = s.pc + 16'h0001;
  assign pc_branch = s.pc + {{9{instr_k[6]}}, instr_k} + 16'h0001;
  assign disp_ok   = (instr_ptr == PTR_SEL_Y) || (instr_ptr == PTR_SEL_Z);

  assign is_io   = (instr_op == OP_IO_BIT_SET) || (instr_op == OP_IO_BIT_CLEAR);
  assign is_load = (instr_op == OP_INDIRECT_LOAD) || (instr_op == OP_LOAD_POST_INC)
                || (instr_op == OP_LOAD_PRE_DEC)
                || ((instr_op == OP_DISPLACED_LOAD) && disp_ok);

  // Memory and I/O read strobes go out in the issue cycle; data returns in the hold cycle
  assign io_rd   = issue && is_io;
  assign io_addr = (s.state == ST_HOLD) ? s.io_addr : instr_io;
  assign dm_rd   = issue && is_load;

  always_comb begin
    unique case (instr_op)
      OP_LOAD_PRE_DEC:   dm_addr = ptr_dec;
      OP_DISPLACED_LOAD: dm_addr = ptr_val + {10'h000, instr_q};
      default:           dm_addr = ptr_val;
    endcase
  end

  // Read-modify-write of the I/O bit lands in the hold cycle
  assign bit_mask = 8'h01 << s.bit_sel;
  assign io_wr    = (s.state == ST_HOLD) && (s.pend == PK_IO);
  assign io_wdata = s.bit_val ? (io_rdata | bit_mask) : (io_rdata & ~bit_mask);

  // Software port address decode
  assign sw_gpr   = (reg_addr <= REG_GPR_LAST);
  assign sw_pc_lo = (reg_addr == REG_PC_LO);
  assign sw_pc_hi = (reg_addr == REG_PC_HI);
  assign sw_flags = (reg_addr == REG_FLAGS);

  // Read selection; unmapped addresses read zero
  always_comb begin
    sw_rbyte = 8'h00;
    if (sw_gpr) begin
      sw_rbyte = s.gpr[reg_addr[4:0]];
    end
    if (sw_pc_lo) begin
      sw_rbyte = s.pc[7:0];
    end
    if (sw_pc_hi) begin
      sw_rbyte = s.pc[15:8];
    end
    if (sw_flags) begin
      sw_rbyte = s.flags;
    end
  end

  always_comb begin
    n = s;

    // Software port, applied before the instruction so execution wins on a clash
    if (reg_rd) begin
      n.rdata = sw_rbyte;
    end
    if (reg_wr) begin
      if (sw_gpr) begin
        n.gpr[reg_addr[4:0]] = reg_wdata;
      end
      if (sw_pc_lo) begin
        n.pc[7:0] = reg_wdata;
      end
      if (sw_pc_hi) begin
        n.pc[15:8] = reg_wdata;
      end
      if (sw_flags) begin
        n.flags = reg_wdata;
      end
    end

    unique case (s.state)
      ST_HOLD: begin
        // Second cycle of a two-cycle instruction
        unique case (s.pend)
          PK_LOAD: begin
            n.gpr[s.dest] = dm_rdata;
          end
          PK_IO: begin
            // Write-back leaves on the I/O port this cycle
          end
          default: begin
            // Taken branch: pc already moved at issue
          end
        endcase
        n.state = ST_RUN;
      end
      ST_RUN: begin
        if (issue) begin
          n.pc = pc_next;
          unique case (instr_op)
            OP_BRANCH_OVERFLOW_CLEAR: begin
              if (!s.flags[FLAG_V]) begin
                n.pc    = pc_branch;
                n.pend  = PK_BRANCH;
                n.state = ST_HOLD;
              end
            end
            OP_BRANCH_IRQ_ON: begin
              if (s.flags[FLAG_I]) begin
                n.pc    = pc_branch;
                n.pend  = PK_BRANCH;
                n.state = ST_HOLD;
              end
            end
            OP_BRANCH_IRQ_OFF: begin
              if (!s.flags[FLAG_I]) begin
                n.pc    = pc_branch;
                n.pend  = PK_BRANCH;
                n.state = ST_HOLD;
              end
            end
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
              n.pend    = PK_IO;
              n.io_addr = instr_io;
              n.bit_sel = instr_bit;
              n.bit_val = (instr_op == OP_IO_BIT_SET);
              n.state   = ST_HOLD;
            end
            OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
            OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH, OP_SWAP_NIBBLES: begin
              n.gpr[instr_rd] = sh_result;
              if (sh_upd) begin
                n.flags[FLAG_C] = sh_c;
                n.flags[FLAG_Z] = sh_z;
                n.flags[FLAG_N] = sh_n;
                n.flags[FLAG_V] = sh_v;
              end
            end
            OP_FLAG_SET: begin
              n.flags[instr_bit] = 1'b1;
            end
            OP_FLAG_CLEAR: begin
              n.flags[instr_bit] = 1'b0;
            end
            OP_COPY_BIT_TO_T: begin
              n.flags[FLAG_T] = s.gpr[instr_rr][instr_bit];
            end
            OP_COPY_T_TO_BIT: begin
              n.gpr[instr_rd][instr_bit] = s.flags[FLAG_T];
            end
            OP_INDIRECT_LOAD: begin
              n.pend  = PK_LOAD;
              n.dest  = instr_rd;
              n.state = ST_HOLD;
            end
            OP_LOAD_POST_INC: begin
              {n.gpr[ptr_hi], n.gpr[ptr_lo]} = ptr_inc;
              n.pend  = PK_LOAD;
              n.dest  = instr_rd;
              n.state = ST_HOLD;
            end
            OP_LOAD_PRE_DEC: begin
              {n.gpr[ptr_hi], n.gpr[ptr_lo]} = ptr_dec;
              n.pend  = PK_LOAD;
              n.dest  = instr_rd;
              n.state = ST_HOLD;
            end
            OP_DISPLACED_LOAD: begin
              // X has no displacement form; treated as no operation
              if (disp_ok) begin
                n.pend  = PK_LOAD;
                n.dest  = instr_rd;
                n.state = ST_HOLD;
              end
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        n.state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= CORE_RST;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata = s.rdata;
  assign pc_out    = s.pc;
  assign flags_out = s.flags;

endmodule : cbl_exec

// File: rtl/cbl_pkg.sv
// Shared constants, opcodes and state types for the bit-op and load execution core
package cbl_pkg;

  // Reset values
  localparam logic [15:0] PC_RST      = 16'h0000;
  localparam logic [7:0]  FLAGS_RST   = 8'h00;

  // Status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Pointer register pairs (low byte index, high byte index)
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_X_HI = 5'h1b;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Y_HI = 5'h1d;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  localparam logic [4:0] PTR_Z_HI = 5'h1f;

  // Pointer select codes
  localparam logic [1:0] PTR_SEL_X = 2'h0;
  localparam logic [1:0] PTR_SEL_Y = 2'h1;
  localparam logic [1:0] PTR_SEL_Z = 2'h2;

  // Software register port map
  localparam logic [5:0] REG_GPR_LAST = 6'h1f;
  localparam logic [5:0] REG_PC_LO    = 6'h3c;
  localparam logic [5:0] REG_PC_HI    = 6'h3d;
  localparam logic [5:0] REG_FLAGS    = 6'h3f;

  // Cycle counts per instruction class
  localparam int CYC_SINGLE       = 1;
  localparam int CYC_BRANCH_TAKEN = 2;
  localparam int CYC_IO_BIT       = 2;
  localparam int CYC_LOAD         = 2;

  typedef enum logic [4:0] {
    OP_NOP                   = 5'h00,
    OP_BRANCH_OVERFLOW_CLEAR = 5'h01,
    OP_BRANCH_IRQ_ON         = 5'h02,
    OP_BRANCH_IRQ_OFF        = 5'h03,
    OP_IO_BIT_SET            = 5'h04,
    OP_IO_BIT_CLEAR          = 5'h05,
    OP_SHIFT_LEFT_LOGICAL    = 5'h06,
    OP_SHIFT_RIGHT_LOGICAL   = 5'h07,
    OP_ROTATE_LEFT_CARRY     = 5'h08,
    OP_ROTATE_RIGHT_CARRY    = 5'h09,
    OP_SHIFT_RIGHT_ARITH     = 5'h0a,
    OP_SWAP_NIBBLES          = 5'h0b,
    OP_FLAG_SET              = 5'h0c,
    OP_FLAG_CLEAR            = 5'h0d,
    OP_COPY_BIT_TO_T         = 5'h0e,
    OP_COPY_T_TO_BIT         = 5'h0f,
    OP_INDIRECT_LOAD         = 5'h10,
    OP_LOAD_POST_INC         = 5'h11,
    OP_LOAD_PRE_DEC          = 5'h12,
    OP_DISPLACED_LOAD        = 5'h13
  } cbl_op_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } cbl_state_t;

  typedef enum logic [1:0] {
    PK_BRANCH = 2'h0,
    PK_IO     = 2'h1,
    PK_LOAD   = 2'h2
  } cbl_pend_t;

  typedef struct packed {
    cbl_state_t       state;
    cbl_pend_t        pend;
    logic [15:0]      pc;
    logic [7:0]       flags;
    logic [31:0][7:0] gpr;
    logic [4:0]       dest;
    logic [5:0]       io_addr;
    logic [2:0]       bit_sel;
    logic             bit_val;
    logic [7:0]       rdata;
  } cbl_core_t;

  localparam cbl_core_t CORE_RST = '{
    state:   ST_RUN,
    pend:    PK_BRANCH,
    pc:      PC_RST,
    flags:   FLAGS_RST,
    gpr:     '0,
    dest:    5'h00,
    io_addr: 6'h00,
    bit_sel: 3'h0,
    bit_val: 1'b0,
    rdata:   8'h00
  };

endpackage : cbl_pkg

// File: rtl/cbl_shifter.sv
// Shift, rotate and nibble-swap datapath with its flag results
`timescale 1ns/1ns
module cbl_shifter
  import cbl_pkg::*;
(
  input  cbl_op_t    op,
  input  logic [7:0] value,
  input  logic       carry_in,
  output logic [7:0] result,
  output logic       carry_out,
  output logic       zero_out,
  output logic       neg_out,
  output logic       ovf_out,
  output logic       flags_upd
);

  always_comb begin
    result    = value;
    carry_out = carry_in;
    flags_upd = 1'b1;
    unique case (op)
      OP_SHIFT_LEFT_LOGICAL: begin
        result    = {value[6:0], 1'b0};
        carry_out = value[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        result    = {1'b0, value[7:1]};
        carry_out = value[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        result    = {value[6:0], carry_in};
        carry_out = value[7];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        result    = {carry_in, value[7:1]};
        carry_out = value[0];
      end
      OP_SHIFT_RIGHT_ARITH: begin
        result    = {value[7], value[7:1]};
        carry_out = value[0];
      end
      OP_SWAP_NIBBLES: begin
        result    = {value[3:0], value[7:4]};
        flags_upd = 1'b0;
      end
      default: begin
        flags_upd = 1'b0;
      end
    endcase
  end

  assign zero_out = (result == 8'h00);
  assign neg_out  = result[7];
  // Overflow follows negative xor carry after the shift
  assign ovf_out  = result[7] ^ carry_out;

endmodule : cbl_shifter

// File: tb/cbl_exec_properties.sv
// Concurrent checks on the execution core ports
`timescale 1ns/1ns
module cbl_exec_properties
  import cbl_pkg::*;
(
  input logic        core_clk,
  input logic        rst_n,
  input logic        instr_valid,
  input logic        instr_ready,
  input cbl_op_t     instr_op,
  input logic [2:0]  instr_bit,
  input logic [5:0]  instr_io,
  input logic [6:0]  instr_k,
  input logic [5:0]  io_addr,
  input logic        io_rd,
  input logic        io_wr,
  input logic [7:0]  io_rdata,
  input logic [7:0]  io_wdata,
  input logic        dm_rd,
  input logic [15:0] pc_out,
  input logic [7:0]  flags_out
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic        tk;
  logic [15:0] tgt;
  logic [15:0] nxt;
  assign tk  = instr_valid && instr_ready;
  assign tgt = pc_out + {{9{instr_k[6]}}, instr_k} + 16'h0001;
  assign nxt = pc_out + 16'h0001;
  sequence take_op(cbl_op_t o);
    tk && instr_op == o;
  endsequence
  sequence hold_then_run;
    !instr_ready ##1 instr_ready;
  endsequence
  a_io_set_write: assert property (take_op(OP_IO_BIT_SET) |=> io_wr && io_addr == $past(instr_io)
    && io_wdata == (io_rdata | (8'h01 << $past(instr_bit)))) else $error("io set write wrong");
  a_io_clr_write: assert property (take_op(OP_IO_BIT_CLEAR) |=> io_wr
    && io_wdata == (io_rdata & ~(8'h01 << $past(instr_bit)))) else $error("io clear write wrong");
  a_io_two_cycles: assert property (take_op(OP_IO_BIT_SET) or take_op(OP_IO_BIT_CLEAR)
    |=> hold_then_run) else $error("io op not two cycles");
  a_io_rd_given: assert property (take_op(OP_IO_BIT_SET) or take_op(OP_IO_BIT_CLEAR)
    |-> io_rd) else $error("io read strobe missing");
  a_io_rd_issue: assert property (io_rd |-> tk && instr_op inside {OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR}) else $error("io read strobe outside io op");
  a_ovf_clr_jump: assert property (take_op(OP_BRANCH_OVERFLOW_CLEAR) ##0 !flags_out[FLAG_V]
    |=> !instr_ready && pc_out == $past(tgt)) else $error("overflow branch not taken");
  a_ovf_clr_skip: assert property (take_op(OP_BRANCH_OVERFLOW_CLEAR) ##0 flags_out[FLAG_V]
    |=> instr_ready && pc_out == $past(nxt)) else $error("overflow branch wrongly taken");
  a_irq_on_jump: assert property (take_op(OP_BRANCH_IRQ_ON) ##0 flags_out[FLAG_I]
    |=> pc_out == $past(tgt)) else $error("irq on branch wrong");
  a_irq_off_jump: assert property (take_op(OP_BRANCH_IRQ_OFF) ##0 !flags_out[FLAG_I]
    |=> pc_out == $past(tgt)) else $error("irq off branch wrong");
  a_swap_flags_kept: assert property (take_op(OP_SWAP_NIBBLES) |=> $stable(flags_out))
    else $error("swap changed flags");
  a_flag_set_one: assert property (take_op(OP_FLAG_SET)
    |=> flags_out == ($past(flags_out) | (8'h01 << $past(instr_bit)))) else $error("flag set wrong");
  a_load_strobe: assert property (tk && instr_op inside {OP_INDIRECT_LOAD, OP_LOAD_POST_INC,
    OP_LOAD_PRE_DEC} |-> dm_rd ##1 !instr_ready) else $error("load strobe or hold wrong");
endmodule : cbl_exec_properties

bind cbl_exec cbl_exec_properties chk (.core_clk, .rst_n, .instr_valid, .instr_ready, .instr_op,
  .instr_bit, .instr_io, .instr_k, .io_addr, .io_rd, .io_wr, .io_rdata, .io_wdata, .dm_rd, .pc_out,
  .flags_out);

// File: tb/test_cbl_exec.sv
// Self-checking bench for the execution core
`timescale 1ns/1ns
module test_cbl_exec;
  import cbl_pkg::*;
  logic        core_clk    = 1'b0;
  logic        rst_n       = 1'b0;
  logic        instr_valid = 1'b0;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  cbl_op_t     instr_op    = OP_NOP;
  logic [4:0]  instr_rd    = 5'h00;
  logic [4:0]  instr_rr    = 5'h00;
  logic [2:0]  instr_bit   = 3'h0;
  logic [5:0]  instr_io    = 6'h00;
  logic [6:0]  instr_k     = 7'h00;
  logic [5:0]  instr_q     = 6'h00;
  logic [1:0]  instr_ptr   = 2'h0;
  logic [7:0]  io_rdata    = 8'h00;
  logic [7:0]  dm_rdata    = 8'h00;
  logic [5:0]  reg_addr    = 6'h00;
  logic [7:0]  reg_wdata   = 8'h00;
  logic        instr_ready, io_rd, io_wr, dm_rd;
  logic [5:0]  io_addr;
  logic [7:0]  io_wdata, reg_rdata, flags_out;
  logic [15:0] dm_addr, pc_out, pcm;
  logic [15:0] expq[$];
  logic        rd_d = 1'b0;
  int          mismatches = 0;
  int          check_count = 0;
  int          cyc = 0;

  cbl_exec dut (.core_clk, .rst_n, .instr_valid, .instr_ready, .instr_op, .instr_rd, .instr_rr,
    .instr_bit, .instr_io, .instr_k, .instr_q, .instr_ptr, .io_addr, .io_rd, .io_rdata, .io_wr,
    .io_wdata, .dm_addr, .dm_rd, .dm_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pc_out, .flags_out);

  initial forever #4 core_clk = ~core_clk;

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task automatic cmp(logic [15:0] got);
    logic [15:0] e;
    e = expq.size() > 0 ? expq.pop_front() : 'x;
    check_count++;
    if (got !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, got);
    end
  endtask : cmp

  // Results are judged where they settle, mid-cycle
  always @(posedge core_clk) rd_d <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_d) cmp({8'h00, reg_rdata});
    if (io_wr) cmp({2'h0, io_addr, io_wdata});
    if (dm_rd) cmp(dm_addr);
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      test_done();
    end
  end

  // Register port write (w=1) or read with expected byte (w=0)
  task automatic acc(logic w, logic [5:0] a, logic [7:0] d);
    if (!w) expq.push_back({8'h00, d});
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask : acc

  task automatic ex(cbl_op_t o, logic [4:0] d, logic [2:0] b);
    instr_op <= o;
    instr_rd <= d;
    instr_bit <= b;
    instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    pcm = pcm + 16'h0001;
    repeat (2) @(posedge core_clk);
  endtask : ex

  initial begin
    logic [7:0]  v, r, f;
    logic [6:0]  kk;
    logic [5:0]  a;
    logic [2:0]  b;
    logic [15:0] pp;
    logic        c;
    int          o, m;
    pcm = 16'h0000;
    void'($urandom(32'h7546));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    f = 8'($urandom);
    acc(1'b1, REG_FLAGS, f);
    for (int i = 0; i < 16; i++) begin
      ex(i[0] ? OP_FLAG_CLEAR : OP_FLAG_SET, 5'h00, 3'(i >> 1));
      f[i >> 1] = !i[0];
      acc(1'b0, REG_FLAGS, f);
    end
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      f = 8'($urandom);
      c = f[FLAG_C];
      acc(1'b1, 6'h05, v);
      acc(1'b1, REG_FLAGS, f);
      case (i)
        0: {c, r} = {v, 1'b0};
        1: {r, c} = {1'b0, v};
        2: {c, r} = {v, c};
        3: {r, c} = {c, v};
        4: {r, c} = {v[7], v};
        default: r = {v[3:0], v[7:4]};
      endcase
      if (i < 5) f[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
      ex(cbl_op_t'(5'h06 + 5'(i)), 5'h05, 3'h0);
      acc(1'b0, 6'h05, r);
      acc(1'b0, REG_FLAGS, f);
    end
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      acc(1'b1, 6'h09, v);
      instr_rr <= 5'h09;
      ex(OP_COPY_BIT_TO_T, 5'h00, 3'(i));
      f[FLAG_T] = v[i];
      acc(1'b0, REG_FLAGS, f);
      ex(OP_COPY_T_TO_BIT, 5'h09, 3'(7 - i));
      v[7 - i] = f[FLAG_T];
      acc(1'b0, 6'h09, v);
    end
    for (int i = 0; i < 6; i++) begin
      f[FLAG_V] = i[0];
      f[FLAG_I] = i[0];
      acc(1'b1, REG_FLAGS, f);
      kk = 7'($urandom);
      instr_k <= kk;
      o = i % 3;
      ex(cbl_op_t'(5'(o + 1)), 5'h00, 3'h0);
      c = o == 0 ? !f[FLAG_V] : (o == 1 ? f[FLAG_I] : !f[FLAG_I]);
      if (c) pcm = pcm + {{9{kk[6]}}, kk};
      acc(1'b0, REG_PC_LO, pcm[7:0]);
      acc(1'b0, REG_PC_HI, pcm[15:8]);
      acc(1'b0, REG_FLAGS, f);
    end
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      a = 6'($urandom);
      b = 3'($urandom);
      io_rdata <= v;
      instr_io <= a;
      expq.push_back({2'h0, a, i[0] ? v & ~(8'h01 << b) : v | (8'h01 << b)});
      ex(i[0] ? OP_IO_BIT_CLEAR : OP_IO_BIT_SET, 5'h00, b);
      acc(1'b0, REG_FLAGS, f);
    end
    for (int i = 0; i < 12; i++) begin
      o = i % 3;
      m = i / 3;
      pp = 16'($urandom);
      v = 8'($urandom);
      a = 6'($urandom);
      acc(1'b1, 6'h1a + 6'(2 * o), pp[7:0]);
      acc(1'b1, 6'h1b + 6'(2 * o), pp[15:8]);
      dm_rdata <= v;
      instr_ptr <= 2'(o);
      instr_q <= a;
      // Displacement from X is no operation: no address, r3 kept
      if (i != 9) begin
        expq.push_back(m == 2 ? pp - 16'h0001 : (m == 3 ? pp + 16'(a) : pp));
        r = v;
      end
      ex(cbl_op_t'(5'h10 + 5'(m)), 5'h03, 3'h0);
      if (m == 1) pp = pp + 16'h0001;
      if (m == 2) pp = pp - 16'h0001;
      acc(1'b0, 6'h03, r);
      acc(1'b0, 6'h1a + 6'(2 * o), pp[7:0]);
      acc(1'b0, 6'h1b + 6'(2 * o), pp[15:8]);
      acc(1'b0, REG_FLAGS, f);
    end
    acc(1'b0, REG_PC_LO, pcm[7:0]);
    acc(1'b0, REG_PC_HI, pcm[15:8]);
    test_done();
  end
endmodule : test_cbl_exec
